/* File: temp_sched_defines.svh */
// Purpose: Named opcodes, field positions, reset values and timing figures of the temperature scheduler.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef TEMP_SCHED_DEFINES_SVH
`define TEMP_SCHED_DEFINES_SVH

// ****************************************
// Register access opcodes
// ****************************************
`define ET2_WR_OPCODE      8'h40
`define ET2_RD_OPCODE      8'hC0
`define ET1_WR_OPCODE_DEF  8'h3A
`define ET1_RD_OPCODE_DEF  8'hBA

// ****************************************
// Field positions
// ****************************************
`define INTERVAL_MSB       6
`define INTERVAL_LSB       1
`define ET1_RSVD_BIT       0
`define COUNT_MSB          15
`define COUNT_LSB          11

// ****************************************
// Reset values and timing
// ****************************************
`define ET1_RESET          16'h0000
`define ET2_RESET          16'h0000
`define CLK_FREQ_HZ        200000000
`define SECOND_S           1
`define SEC_CYCLES_DEF     (`CLK_FREQ_HZ * `SECOND_S)
`define INTERVAL_BASE_S    7'h01
`define CYCLE_BASE         6'h01

`endif

/* File: temp_sched_pkg.sv */
// Purpose: Types shared by the temperature scheduler files.
// Assumes: Nothing.
// Notes:   State of sec_tick and of the scheduler is one packed struct each.
package temp_sched_pkg;

   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_SEQ_FULL,
      CMD_SEQ_TEMP,
      CMD_OTHER
   } seq_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_WAIT
   } sched_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  opcode;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } reg_rsp_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } tick_state_t;

   typedef struct packed {
      logic [15:0]  et1;
      logic [15:0]  et2;
      sched_state_t st;
      logic [5:0]   cycles_left;
      logic [6:0]   sec_cnt;
      logic         start_p;
      logic         seq_done_p;
      logic         active;
      reg_rsp_t     rsp;
   } sched_state_s_t;

endpackage

/* File: sec_tick.sv */
// Purpose: One-second tick from the system clock, realignable at each cycle start.
// Assumes: clk at 200 MHz.
// Notes:   The tick is a one-cycle pulse registered in the state struct.
`timescale 1ns/100ps
`include "temp_sched_defines.svh"

module sec_tick #(
   parameter int unsigned SEC_CYCLES = `SEC_CYCLES_DEF
) (
   input  wire logic clk,      // System clock.
   input  wire logic rstn,     // Asynchronous reset, active low.
   input  wire logic restart,  // Realign the second to this cycle.
   output logic      tick_q    // One-cycle pulse each elapsed second.
);
   import temp_sched_pkg::*;

   tick_state_t s_q;
   tick_state_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (restart) begin
         s_d.cnt = 32'h0000_0000;
      end else if (s_q.cnt == 32'(SEC_CYCLES - 1)) begin
         s_d.cnt  = 32'h0000_0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_q = s_q.tick;

endmodule

/* File: temp_event_timing_scheduler.sv */
// Purpose: Temperature part of the event timing scheduler: interval and cycle count.
// Assumes: Register requests come already decoded from the serial command port.
// Notes:   Both configuration words reset to their flash default of zero.
`timescale 1ns/100ps
`include "temp_sched_defines.svh"

// Notes on behaviour
// - Interval runs from one temperature cycle start to the next start.
// - Interval only schedules during the full or temperature event sequence commands.
// - Interval code in bits 6:1 gives (code+1) seconds; bit 0 is reserved.
// - Count code in bits 15:11 of second register gives code+1 cycles.
// - Count reloads at each such command accepted while idle; temperature part ends after last cycle.
module temp_event_timing_scheduler #(
   parameter int unsigned SEC_CYCLES = `SEC_CYCLES_DEF,   // Clock cycles per second.
   parameter logic [7:0]  ET1_WR_OP  = `ET1_WR_OPCODE_DEF, // Write opcode of first register.
   parameter logic [7:0]  ET1_RD_OP  = `ET1_RD_OPCODE_DEF  // Read opcode of first register.
) (
   input  wire logic                      clk,            // System clock.
   input  wire logic                      rstn,           // Asynchronous reset, active low.
   input  temp_sched_pkg::reg_req_t       reg_req,        // Decoded register request.
   output temp_sched_pkg::reg_rsp_t       reg_rsp,        // Registered read answer.
   input  wire logic                      cmd_valid,      // Event command strobe.
   input  temp_sched_pkg::seq_cmd_t       cmd,            // Event command code.
   input  wire logic                      cmd_abort,      // Halt any running sequence.
   input  wire logic                      temp_cycle_done, // Measurement engine finished a cycle.
   output logic                           temp_start_q,   // Pulse: start one temperature cycle.
   output logic                           temp_active_q,  // Temperature sequence running.
   output logic                           temp_seq_done_q, // Pulse: temperature sequence ended.
   output logic [5:0]                     cycles_left_q   // Cycles still to start.
);
   import temp_sched_pkg::*;

   sched_state_s_t s_q;
   sched_state_s_t s_d;
   logic           sec_tick_w;

   // ****************************************
   // Second base
   // ****************************************
   sec_tick #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_sec_tick (
      .clk     (clk),
      .rstn    (rstn),
      .restart (s_q.start_p),
      .tick_q  (sec_tick_w)
   );

   function automatic logic is_temp_cmd(input seq_cmd_t c);
      is_temp_cmd = (c == CMD_SEQ_FULL) || (c == CMD_SEQ_TEMP);
   endfunction

   function automatic logic [6:0] interval_s(input logic [15:0] et1);
      interval_s = {1'b0, et1[`INTERVAL_MSB:`INTERVAL_LSB]} + `INTERVAL_BASE_S;
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d            = s_q;
      s_d.start_p    = 1'b0;
      s_d.seq_done_p = 1'b0;
      s_d.rsp.valid  = 1'b0;

      if (reg_req.wr) begin
         if (reg_req.opcode == ET1_WR_OP) begin
            // The reserved bit is not stored, so it always reads back as zero.
            s_d.et1                = reg_req.wdata;
            s_d.et1[`ET1_RSVD_BIT] = 1'b0;
         end else if (reg_req.opcode == `ET2_WR_OPCODE) begin
            s_d.et2 = reg_req.wdata;
         end
      end
      if (reg_req.rd) begin
         s_d.rsp.valid = 1'b1;
         if (reg_req.opcode == ET1_RD_OP) begin
            s_d.rsp.data = s_q.et1;
         end else if (reg_req.opcode == `ET2_RD_OPCODE) begin
            s_d.rsp.data = s_q.et2;
         end else begin
            s_d.rsp.data = 16'h0000;
         end
      end

      if (sec_tick_w && (s_q.sec_cnt != 7'h7F)) begin
         s_d.sec_cnt = s_q.sec_cnt + 7'h01;
      end

      unique case (s_q.st)
         ST_IDLE: begin
            if (cmd_valid && is_temp_cmd(cmd) && !cmd_abort) begin
               // Count is taken afresh from the register at every accepted command.
               s_d.cycles_left = {1'b0, s_q.et2[`COUNT_MSB:`COUNT_LSB]} + `CYCLE_BASE - 6'h01;
               s_d.start_p     = 1'b1;
               s_d.sec_cnt     = 7'h00;
               s_d.active      = 1'b1;
               s_d.st          = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cmd_abort) begin
               s_d.st          = ST_IDLE;
               s_d.active      = 1'b0;
               s_d.cycles_left = 6'h00;
               s_d.seq_done_p  = 1'b1;
            end else if (temp_cycle_done) begin
               if (s_q.cycles_left == 6'h00) begin
                  s_d.st         = ST_IDLE;
                  s_d.active     = 1'b0;
                  s_d.seq_done_p = 1'b1;
               end else begin
                  s_d.st = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            // Timing counts from the previous start, not from the cycle end.
            // A cycle longer than the interval makes the next start follow at once.
            if (cmd_abort) begin
               s_d.st          = ST_IDLE;
               s_d.active      = 1'b0;
               s_d.cycles_left = 6'h00;
               s_d.seq_done_p  = 1'b1;
            end else if (s_d.sec_cnt >= interval_s(s_q.et1)) begin
               s_d.cycles_left = s_q.cycles_left - 6'h01;
               s_d.start_p     = 1'b1;
               s_d.sec_cnt     = 7'h00;
               s_d.st          = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q     <= '0;
         s_q.et1 <= `ET1_RESET;
         s_q.et2 <= `ET2_RESET;
         s_q.st  <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rsp         = s_q.rsp;
   assign temp_start_q    = s_q.start_p;
   assign temp_active_q   = s_q.active;
   assign temp_seq_done_q = s_q.seq_done_p;
   assign cycles_left_q   = s_q.cycles_left;

endmodule

/* File: temp_sched_sva.sv */
// Purpose: Port assertions for the temperature scheduler.
// Assumes: Bound to the top module.
// Notes:   Code fields are tracked from register writes.
`timescale 1ns/100ps
module temp_sched_sva
   import temp_sched_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = 10,
   parameter logic [7:0]  ET1_WR_OP  = 8'h3A,
   parameter logic [7:0]  ET1_RD_OP  = 8'hBA
) (
   input wire logic                clk,             // Clock.
   input wire logic                rstn,            // Reset, active low.
   input temp_sched_pkg::reg_req_t reg_req,         // Register request.
   input temp_sched_pkg::reg_rsp_t reg_rsp,         // Read answer.
   input wire logic                cmd_valid,       // Command strobe.
   input temp_sched_pkg::seq_cmd_t cmd,             // Command code.
   input wire logic                cmd_abort,       // Abort.
   input wire logic                temp_cycle_done, // Engine done.
   input wire logic                temp_start_q,    // Start pulse.
   input wire logic                temp_active_q,   // Sequence running.
   input wire logic                temp_seq_done_q, // Sequence ended.
   input wire logic [5:0]          cycles_left_q    // Starts remaining.
);
   logic [5:0]  ivl_code_q;
   logic [4:0]  cnt_code_q;
   logic [31:0] gap_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ivl_code_q <= '0;
         cnt_code_q <= '0;
         gap_q      <= '0;
      end else begin
         gap_q <= temp_start_q ? 32'h0000_0001 : gap_q + 32'h0000_0001;
         if (reg_req.wr && reg_req.opcode == ET1_WR_OP) ivl_code_q <= reg_req.wdata[6:1];
         if (reg_req.wr && reg_req.opcode == 8'h40) cnt_code_q <= reg_req.wdata[15:11];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_accept;
      cmd_valid && (cmd == CMD_SEQ_FULL || cmd == CMD_SEQ_TEMP) && !temp_active_q && !cmd_abort;
   endsequence
   sequence s_last_done;
      temp_active_q && temp_cycle_done && cycles_left_q == 6'h00 && !temp_start_q;
   endsequence
   AST_ACCEPT: assert property (s_accept |=> temp_start_q && temp_active_q) else $error("no start");
   AST_IGNORE_OTHER: assert property (cmd_valid && cmd == CMD_OTHER && !temp_active_q |=> !temp_active_q)
      else $error("other code started");
   AST_START_ACTIVE: assert property (temp_start_q |-> temp_active_q) else $error("idle start");
   AST_COUNT_LOAD: assert property (s_accept |=> cycles_left_q == {1'b0, cnt_code_q}) else $error("bad count");
   AST_COUNT_STEP: assert property (temp_start_q && $past(temp_active_q) |->
      cycles_left_q == $past(cycles_left_q) - 6'h01) else $error("bad step");
   AST_SPACING: assert property (temp_start_q && $past(temp_active_q) |->
      gap_q >= SEC_CYCLES * (32'(ivl_code_q) + 1)) else $error("starts too close");
   AST_SEQ_END: assert property (s_last_done |=> !temp_active_q && temp_seq_done_q) else $error("no end");
   AST_RSVD_READ: assert property (reg_req.rd && reg_req.opcode == ET1_RD_OP |=>
      reg_rsp.valid && !reg_rsp.data[0]) else $error("bad read");
endmodule

/* File: temp_engine_model.sv */
// Purpose: Measurement engine standing behind the scheduler.
// Assumes: One cycle in flight at a time.
// Notes:   Cycle length is set live, so slow and prompt cycles both occur.
`timescale 1ns/100ps
module temp_engine_model (
   input  wire logic       clk,   // Clock.
   input  wire logic       rstn,  // Reset, active low.
   input  wire logic       start, // Cycle start.
   input  wire logic [7:0] dly,   // Cycle length in clocks.
   output logic            done   // End-of-cycle pulse.
);
   int cnt;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt = 0;
         done <= 1'b0;
      end else begin
         done <= (cnt == 1);
         cnt = start ? int'(dly) : (cnt > 0 ? cnt - 1 : 0);
      end
   end
endmodule

/* File: temp_event_timing_scheduler_bench.sv */
// Purpose: Self-checking bench of the temperature scheduler.
// Assumes: Short second of ten clocks.
// Notes:   Expected figures come from the code fields written.
`timescale 1ns/100ps
`include "temp_sched_defines.svh"
module temp_event_timing_scheduler_bench;
   import temp_sched_pkg::*;
   localparam int SC = 10;
   logic      clk = 0, rstn = 0, cmd_valid, cmd_abort, done, start, active, sdone;
   logic [7:0] dly;
   logic [5:0] left;
   logic [31:0] rnd;
   reg_req_t  req;
   reg_rsp_t  rsp;
   seq_cmd_t  cmd;
   int        bad_count, samples_checked, nstarts, gap, n_exp, ivl, cnt_code;
   always #2.5 clk = ~clk;
   temp_event_timing_scheduler #(.SEC_CYCLES(SC)) u_temp_event_timing_scheduler (.clk, .rstn, .reg_req(req),
      .reg_rsp(rsp), .cmd_valid, .cmd, .cmd_abort, .temp_cycle_done(done), .temp_start_q(start),
      .temp_active_q(active), .temp_seq_done_q(sdone), .cycles_left_q(left));
   temp_engine_model u_temp_engine_model (.clk, .rstn, .start, .dly, .done);
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task check(string nm, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wr(logic [7:0] op, logic [15:0] d);
      @(posedge clk) #1 req.wr = 1;
      req.opcode = op;
      req.wdata = d;
      @(posedge clk) #1 req.wr = 0;
   endtask
   task rd(logic [7:0] op, logic [15:0] exp);
      @(posedge clk) #1 req.rd = 1;
      req.opcode = op;
      @(posedge clk) #1 req.rd = 0;
      check("read", {rsp.valid, rsp.data}, {1'b1, exp});
   endtask
   always @(negedge clk) if (start) begin
      if (nstarts > 0) check("gap", gap >= n_exp && gap <= (n_exp > dly + 2 ? n_exp : dly + 2) + 2, 1);
      check("left", left, cnt_code - nstarts);
      nstarts++;
      gap = 1;
   end else gap++;
   task run(seq_cmd_t c, int exp_n, int lim);
      int i;
      @(posedge clk) #1 nstarts = 0;
      cmd_valid = 1;
      cmd = c;
      @(posedge clk) #1 cmd_valid = 0;
      for (i = 0; i < lim && sdone !== 1'b1; i++) @(negedge clk);
      if (exp_n > 0 && i == lim) begin
         check("timeout", 0, 1);
         print_verdict;
      end
      check("starts", nstarts, exp_n);
   endtask
   initial begin
      req = '0;
      cmd_valid = 0;
      cmd = CMD_NONE;
      cmd_abort = 0;
      dly = 8'h04;
      rnd = lfsr(32'h0000_764a);
      repeat (8) @(posedge clk);
      #1 rstn = 1;
      rd(`ET1_RD_OPCODE_DEF, 16'h0000);
      rd(`ET2_RD_OPCODE, 16'h0000);
      ivl = rnd % 3;
      cnt_code = 1 + rnd[9:8] % 3;
      wr(`ET1_WR_OPCODE_DEF, {rnd[24:16], 6'(ivl), 1'b0});
      wr(`ET2_WR_OPCODE, {5'(cnt_code), rnd[10:0]});
      rd(`ET1_RD_OPCODE_DEF, {rnd[24:16], 6'(ivl), 1'b0});
      rd(`ET2_RD_OPCODE, {5'(cnt_code), rnd[10:0]});
      rd(8'h00, 16'h0000);
      n_exp = SC * (ivl + 1);
      run(CMD_OTHER, 0, 40);
      dly = 8'h04 + rnd[1:0];
      run(CMD_SEQ_FULL, cnt_code + 1, 1000);
      dly = 8'h28;
      run(CMD_SEQ_TEMP, cnt_code + 1, 1000);
      @(posedge clk) #1 nstarts = 0;
      cmd_valid = 1;
      cmd = CMD_SEQ_FULL;
      @(posedge clk) #1 cmd_valid = 0;
      @(posedge clk) #1 cmd_abort = 1;
      @(posedge clk) #1 cmd_abort = 0;
      check("abort", {sdone, active}, 2'b10);
      print_verdict;
   end
endmodule
bind temp_event_timing_scheduler temp_sched_sva #(.SEC_CYCLES(SEC_CYCLES), .ET1_WR_OP(ET1_WR_OP),
   .ET1_RD_OP(ET1_RD_OP)) u_temp_sched_sva (.clk, .rstn, .reg_req, .reg_rsp, .cmd_valid, .cmd, .cmd_abort,
   .temp_cycle_done, .temp_start_q, .temp_active_q, .temp_seq_done_q, .cycles_left_q);
